// ### uvsp_pkg.sv
// Constants shared by the sensor's serial slave port.
// Assumes a 20 MHz system clock and a standard-mode two-wire bus host.
package uvsp_pkg;

  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned TIMEOUT_MIN_MS  = 25;
  localparam int unsigned TIMEOUT_MAX_MS  = 35;
  // Least timeout in whole cycles, with the division rounded down.
  localparam int unsigned TIMEOUT_CYC_DEF = (CLK_HZ / 1000 * TIMEOUT_MIN_MS);

  localparam logic [6:0] ADDR_MAIN = 7'h38;
  localparam logic [6:0] ADDR_MSB  = 7'h39;
  localparam logic [6:0] ADDR_ARA  = 7'h18;

  localparam logic [7:0] CMD_RESET = 8'h06;
  localparam int unsigned CMD_SD   = 0;
  localparam int unsigned CMD_ITF_LO = 2;
  localparam int unsigned CMD_ITF_HI = 3;
  localparam int unsigned CMD_THD  = 4;
  localparam int unsigned CMD_ACK  = 5;

  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BIT_LAST  = 4'h7;

  localparam logic [1:0] SEL_LSB = 2'h0;
  localparam logic [1:0] SEL_MSB = 2'h1;
  localparam logic [1:0] SEL_ARA = 2'h2;

  typedef enum logic [2:0] {
    UVSP_IDLE, UVSP_ADDR, UVSP_ADDR_ACK, UVSP_RD_BYTE,
    UVSP_RD_ACK, UVSP_WR_BYTE, UVSP_WR_ACK, UVSP_IGNORE
  } uvsp_state_e;

endpackage

// ### uvsp_i2c_slave.sv
// Serial slave port of the UV sensor: command byte, light data reads, alert response.
// Assumes SCL and SDA come straight from pins; light data and alert events come from
// the sensor core on clk.
// What this block does
// - One eight-bit command register is held and only a bus write can load it.
// - Every sensor setting output comes from the command register alone.
// - A read is start, address with read bit, ack, one data byte, host nack, stop.
// - The port acknowledges its own address by pulling SDA low in the ack slot.
// - Clock or data low for the timeout period abandons the transfer and frees SDA.
// - Reads of 38h and 39h return the latched light result, kept apart from the command setting.
// - A write is start, address with write bit, ack, one command byte, ack, stop.
// - Address 38h takes writes and gives the low byte, 39h gives the high byte only.
// - The integration time field resets to binary 01.
// - Reading the alert response address 18h answers and clears a pending alert.
`timescale 1ns/10ps
module uvsp_i2c_slave
  import uvsp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = uvsp_pkg::TIMEOUT_CYC_DEF
)(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             alert_o,
  output logic             alert_oe,
  input  wire logic [15:0] light_data,
  input  wire logic        light_valid,
  input  wire logic        alert_event,
  output logic [7:0]       cmd_byte,
  output logic             cmd_shutdown,
  output logic [1:0]       cmd_integration_time_field,
  output logic             cmd_ack_threshold,
  output logic             cmd_ack_enable
);
  import uvsp_pkg::*;

  localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYC - 1);
  localparam logic [TW-1:0] TMO_FULL = TW'(TIMEOUT_CYC);

  logic [1:0]  scl_meta_r;
  logic [1:0]  sda_meta_r;
  logic        scl_d_r;
  logic        sda_d_r;
  uvsp_state_e st_r, st_nxt;
  logic [3:0]  bitcnt_r, bitcnt_nxt;
  logic [7:0]  rx_r, rx_nxt;
  logic [7:0]  tx_r, tx_nxt;
  logic        oe_r, oe_nxt;
  logic [1:0]  sel_r, sel_nxt;
  logic [7:0]  cmd_r, cmd_nxt;
  logic [15:0] data_r;
  logic        alert_r;
  logic [TW-1:0] tmo_cnt_r;
  logic        ara_done;

  wire scl_s    = scl_meta_r[1];
  wire sda_s    = sda_meta_r[1];
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire bus_low  = ~scl_s | ~sda_s;
  wire tmo      = bus_low & (tmo_cnt_r == TMO_LAST);

  wire [6:0] addr7   = rx_r[7:1];
  wire       rw      = rx_r[0];
  wire       hit_lsb = (addr7 == ADDR_MAIN);
  wire       hit_msb = (addr7 == ADDR_MSB) & rw;
  wire       hit_ara = (addr7 == ADDR_ARA) & rw & alert_r;
  wire       hit     = hit_lsb | hit_msb | hit_ara;
  wire [1:0] sel_hit = hit_ara ? SEL_ARA : (hit_msb ? SEL_MSB : SEL_LSB);
  wire [7:0] sel_byte = (sel_r == SEL_ARA) ? {ADDR_MAIN, 1'b0} :
                        (sel_r == SEL_MSB) ? data_r[15:8] : data_r[7:0];

  assign sda_o    = 1'b0;
  assign sda_oe   = oe_r;
  assign alert_o  = 1'b0;
  assign alert_oe = alert_r & cmd_r[CMD_ACK];
  assign cmd_byte                   = cmd_r;
  assign cmd_shutdown               = cmd_r[CMD_SD];
  assign cmd_integration_time_field = cmd_r[CMD_ITF_HI:CMD_ITF_LO];
  assign cmd_ack_threshold          = cmd_r[CMD_THD];
  assign cmd_ack_enable             = cmd_r[CMD_ACK];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_meta_r <= 2'h3;
      sda_meta_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end
    else
    begin
      scl_meta_r <= {scl_meta_r[0], scl_i};
      sda_meta_r <= {sda_meta_r[0], sda_i};
      scl_d_r    <= scl_s;
      sda_d_r    <= sda_s;
    end
  end

  // Low-time counter saturates so that one stuck-low period fires once.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      tmo_cnt_r <= '0;
    else if (!bus_low)
      tmo_cnt_r <= '0;
    else if (tmo_cnt_r != TMO_FULL)
      tmo_cnt_r <= tmo_cnt_r + TW'(1);
  end

  always_comb
  begin
    st_nxt     = st_r;
    bitcnt_nxt = bitcnt_r;
    rx_nxt     = rx_r;
    tx_nxt     = tx_r;
    oe_nxt     = oe_r;
    sel_nxt    = sel_r;
    cmd_nxt    = cmd_r;
    ara_done   = 1'b0;
    if (tmo)
    begin
      st_nxt = UVSP_IDLE;
      oe_nxt = 1'b0;
    end
    else if (start_c)
    begin
      st_nxt     = UVSP_ADDR;
      bitcnt_nxt = '0;
      oe_nxt     = 1'b0;
    end
    else if (stop_c)
    begin
      st_nxt = UVSP_IDLE;
      oe_nxt = 1'b0;
    end
    else
    begin
      unique case (st_r)
        UVSP_IDLE, UVSP_IGNORE:
        begin
        end
        UVSP_ADDR:
        begin
          if (scl_rise && bitcnt_r != BITS_BYTE)
          begin
            rx_nxt     = {rx_r[6:0], sda_s};
            bitcnt_nxt = bitcnt_r + 4'h1;
          end
          else if (scl_fall && bitcnt_r == BITS_BYTE)
          begin
            if (hit)
            begin
              st_nxt  = UVSP_ADDR_ACK;
              oe_nxt  = 1'b1;
              sel_nxt = sel_hit;
            end
            else
              st_nxt = UVSP_IGNORE;
          end
        end
        UVSP_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            bitcnt_nxt = '0;
            if (rw)
            begin
              st_nxt = UVSP_RD_BYTE;
              tx_nxt = sel_byte;
              oe_nxt = ~sel_byte[7];
            end
            else
            begin
              st_nxt = UVSP_WR_BYTE;
              oe_nxt = 1'b0;
            end
          end
        end
        UVSP_RD_BYTE:
        begin
          if (scl_fall)
          begin
            if (bitcnt_r == BIT_LAST)
            begin
              st_nxt = UVSP_RD_ACK;
              oe_nxt = 1'b0;
            end
            else
            begin
              tx_nxt     = {tx_r[6:0], 1'b0};
              oe_nxt     = ~tx_r[6];
              bitcnt_nxt = bitcnt_r + 4'h1;
            end
          end
        end
        UVSP_RD_ACK:
        begin
          if (scl_rise)
          begin
            st_nxt   = UVSP_IGNORE;
            ara_done = (sel_r == SEL_ARA);
          end
        end
        UVSP_WR_BYTE:
        begin
          if (scl_rise && bitcnt_r != BITS_BYTE)
          begin
            rx_nxt     = {rx_r[6:0], sda_s};
            bitcnt_nxt = bitcnt_r + 4'h1;
          end
          else if (scl_fall && bitcnt_r == BITS_BYTE)
          begin
            cmd_nxt = rx_r;
            st_nxt  = UVSP_WR_ACK;
            oe_nxt  = 1'b1;
          end
        end
        UVSP_WR_ACK:
        begin
          if (scl_fall)
          begin
            st_nxt = UVSP_IGNORE;
            oe_nxt = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r     <= UVSP_IDLE;
      bitcnt_r <= '0;
      rx_r     <= '0;
      tx_r     <= '0;
      oe_r     <= 1'b0;
      sel_r    <= SEL_LSB;
      cmd_r    <= CMD_RESET;
    end
    else
    begin
      st_r     <= st_nxt;
      bitcnt_r <= bitcnt_nxt;
      rx_r     <= rx_nxt;
      tx_r     <= tx_nxt;
      oe_r     <= oe_nxt;
      sel_r    <= sel_nxt;
      cmd_r    <= cmd_nxt;
    end
  end

  // A new alert arriving with the clearing read wins.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      data_r  <= '0;
      alert_r <= 1'b0;
    end
    else
    begin
      if (light_valid)
        data_r <= light_data;
      alert_r <= alert_event | (alert_r & ~ara_done);
    end
  end

  logic wrote_r;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      wrote_r <= 1'b0;
    else if (st_nxt == UVSP_WR_ACK)
      wrote_r <= 1'b1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_addr_done;
    (st_r == UVSP_ADDR) && scl_fall && (bitcnt_r == BITS_BYTE) && !start_c && !stop_c && !tmo;
  endsequence

  sequence s_wr_done;
    (st_r == UVSP_WR_BYTE) && scl_fall && (bitcnt_r == BITS_BYTE) && !start_c && !stop_c && !tmo;
  endsequence

  chk_cmd_bus_only: assert property ($changed(cmd_r) |-> $past(st_r) == UVSP_WR_BYTE)
    else $error("Command register changed outside a bus write.");
  chk_cmd_fields: assert property (
    cmd_integration_time_field == cmd_byte[CMD_ITF_HI:CMD_ITF_LO]
    && cmd_shutdown == cmd_byte[CMD_SD])
    else $error("Setting outputs disagree with the command byte.");
  chk_rd_one_byte: assert property (
    (st_r == UVSP_RD_ACK) && scl_rise && !start_c && !stop_c && !tmo
    |=> (st_r == UVSP_IGNORE) && !oe_r)
    else $error("Read did not end after one byte.");
  chk_addr_ack_drive: assert property (
    s_addr_done ##0 hit |=> (st_r == UVSP_ADDR_ACK) && sda_oe)
    else $error("Own address was not acknowledged.");
  chk_timeout_release: assert property (tmo |=> (st_r == UVSP_IDLE) && !sda_oe)
    else $error("Bus timeout did not release the port.");
  chk_data_latch: assert property (light_valid |=> data_r == $past(light_data))
    else $error("Light result was not latched.");
  chk_wr_ack_cmd: assert property (
    s_wr_done |=> (st_r == UVSP_WR_ACK) && sda_oe && cmd_r == $past(rx_r))
    else $error("Command byte was not taken and acknowledged.");
  chk_msb_no_write: assert property (
    s_addr_done ##0 ((addr7 == ADDR_MSB) && !rw) |=> st_r == UVSP_IGNORE)
    else $error("Write to the high-byte address was accepted.");
  chk_it_default: assert property (
    !wrote_r |-> cmd_integration_time_field == CMD_RESET[CMD_ITF_HI:CMD_ITF_LO])
    else $error("Integration time field left its default without a write.");
  chk_ara_clear: assert property (ara_done && !alert_event |=> !alert_r)
    else $error("Alert response read did not clear the alert.");
  chk_foreign_ignore: assert property (
    s_addr_done ##0 !hit |=> (st_r == UVSP_IGNORE) && !sda_oe)
    else $error("Foreign address was not ignored.");
  chk_ignore_release: assert property (st_r == UVSP_IGNORE |-> !sda_oe)
    else $error("SDA driven while ignoring a transfer.");

endmodule // uvsp_i2c_slave

// ### uvsp_host_model.sv
// Behavioural two-wire bus host that pulls the clock and data lines low on demand.
// Assumes the bench resolves both open-drain lines with pull-ups from the low enables.
`timescale 1ns/10ps
module uvsp_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  localparam int HP = 10;
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves only while the clock is low and is sampled in the middle of the high phase.
  task automatic put_bit(input logic b, output logic seen);
    wait_clk(HP / 2);
    sda_low <= ~b;
    wait_clk(HP / 2);
    scl_low <= 1'b0;
    wait_clk(HP / 2);
    seen = sda;
    wait_clk(HP / 2);
    scl_low <= 1'b1;
  endtask
  task automatic bus_start;
    sda_low <= 1'b1;
    wait_clk(HP);
    scl_low <= 1'b1;
  endtask
  task automatic bus_stop;
    wait_clk(HP / 2);
    sda_low <= 1'b1;
    wait_clk(HP / 2);
    scl_low <= 1'b0;
    wait_clk(HP);
    sda_low <= 1'b0;
    wait_clk(HP);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(1'b1, s);
      b[i] = s;
    end
    put_bit(nack, s);
  endtask
endmodule // uvsp_host_model

// ### test_uvsp_i2c_slave.sv
// Self-checking bench for the sensor's serial slave port.
// Assumes the host model drives the bus and the bench plays the sensor core.
`timescale 1ns/10ps
module test_uvsp_i2c_slave;
  import uvsp_pkg::*;
  // A run of zero bits keeps a line low for a few hundred cycles, so stay well above it.
  localparam int TO_CYC = 1000;
  logic        clk, nrst, light_valid, alert_event, alert_pend, ack;
  logic [15:0] light_data, ld;
  logic        scl_low, sda_low, sda_o, sda_oe, alert_o, alert_oe;
  logic [7:0]  cmd_byte, cmd_exp, rd;
  logic        cmd_shutdown, cmd_ack_threshold, cmd_ack_enable;
  logic [1:0]  cmd_integration_time_field;
  logic [6:0]  a;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          seed = 47;
  int          oe_cnt = 0;
  int          oe_base;
  wire scl_w = ~scl_low;
  wire sda_w = ~(sda_low | sda_oe);
  uvsp_host_model i_uvsp_host_model (.clk(clk), .sda(sda_w), .scl_low(scl_low),
    .sda_low(sda_low));
  uvsp_i2c_slave #(.TIMEOUT_CYC(TO_CYC)) i_uvsp_i2c_slave (.clk(clk), .nrst(nrst),
    .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .alert_o(alert_o),
    .alert_oe(alert_oe), .light_data(light_data), .light_valid(light_valid),
    .alert_event(alert_event), .cmd_byte(cmd_byte), .cmd_shutdown(cmd_shutdown),
    .cmd_integration_time_field(cmd_integration_time_field),
    .cmd_ack_threshold(cmd_ack_threshold), .cmd_ack_enable(cmd_ack_enable));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) oe_cnt <= oe_cnt + int'(sda_oe);
  function automatic logic exp_ack(input logic [6:0] ad, input logic rdb);
    return ad == ADDR_MAIN || (rdb && ad == ADDR_MSB) || (rdb && alert_pend && ad == ADDR_ARA);
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_cmd;
    check("cmd_byte", {8'h0, cmd_exp}, {8'h0, cmd_byte});
    check("fields", {11'h0, cmd_exp[5:2], cmd_exp[0]}, {11'h0, cmd_ack_enable,
      cmd_ack_threshold, cmd_integration_time_field, cmd_shutdown});
  endtask
  task automatic xfer_wr(input logic [6:0] ad, input logic [7:0] d);
    logic e;
    e = exp_ack(ad, 1'b0);
    i_uvsp_host_model.bus_start();
    i_uvsp_host_model.send_byte({ad, 1'b0}, ack);
    check("addr ack", {15'h0, e}, {15'h0, ack});
    i_uvsp_host_model.send_byte(d, ack);
    check("data ack", {15'h0, e}, {15'h0, ack});
    i_uvsp_host_model.bus_stop();
    if (e) cmd_exp = d;
    chk_cmd();
  endtask
  task automatic xfer_rd(input logic [6:0] ad, input logic [7:0] d);
    logic e;
    e = exp_ack(ad, 1'b1);
    i_uvsp_host_model.bus_start();
    i_uvsp_host_model.send_byte({ad, 1'b1}, ack);
    check("addr ack", {15'h0, e}, {15'h0, ack});
    i_uvsp_host_model.recv_byte(1'b1, rd);
    check("read byte", {8'h0, e ? d : 8'hff}, {8'h0, rd});
    i_uvsp_host_model.bus_stop();
  endtask
  task automatic latch_light(input logic [15:0] v);
    @(posedge clk);
    light_data <= v;
    light_valid <= 1'b1;
    @(posedge clk);
    light_valid <= 1'b0;
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    nrst = 1'b0;
    light_valid = 1'b0;
    alert_event = 1'b0;
    light_data = 16'h0;
    alert_pend = 1'b0;
    cmd_exp = CMD_RESET;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    chk_cmd();
    check("open drain low", 16'h0, {14'h0, sda_o, alert_o});
    $display("test reset done");
    for (int k = 0; k < 6; k++) xfer_wr(ADDR_MAIN, k == 0 ? 8'hff : 8'($random(seed)));
    $display("test command write done");
    for (int k = 0; k < 4; k++)
    begin
      ld = k == 0 ? 16'h807f : 16'($random(seed));
      latch_light(ld);
      xfer_rd(ADDR_MAIN, ld[7:0]);
      xfer_rd(ADDR_MSB, ld[15:8]);
      chk_cmd();
    end
    $display("test light read done");
    xfer_wr(ADDR_MSB, 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      a = 7'($random(seed));
      if (a == ADDR_MAIN || a == ADDR_MSB || a == ADDR_ARA) a = 7'h55;
      oe_base = oe_cnt;
      if (k[0]) xfer_rd(a, 8'hff);
      else xfer_wr(a, 8'h5a);
      check("sda released", 16'h0, 16'(oe_cnt - oe_base));
    end
    xfer_rd(ADDR_ARA, 8'hff);
    $display("test refusal done");
    xfer_wr(ADDR_MAIN, CMD_RESET);
    @(posedge clk);
    alert_event <= 1'b1;
    @(posedge clk);
    alert_event <= 1'b0;
    alert_pend = 1'b1;
    repeat (2) @(posedge clk);
    check("alert pin off", 16'h0, {15'h0, alert_oe});
    xfer_wr(ADDR_MAIN, 8'h26);
    check("alert pin", 16'h1, {15'h0, alert_oe});
    xfer_rd(ADDR_ARA, {ADDR_MAIN, 1'b0});
    alert_pend = 1'b0;
    check("alert pin", 16'h0, {15'h0, alert_oe});
    xfer_rd(ADDR_ARA, 8'hff);
    $display("test alert done");
    latch_light(16'h1234);
    i_uvsp_host_model.bus_start();
    i_uvsp_host_model.send_byte({ADDR_MAIN, 1'b1}, ack);
    i_uvsp_host_model.wait_clk(5);
    check("data driven", 16'h1, {15'h0, sda_oe});
    i_uvsp_host_model.wait_clk(TO_CYC + 20);
    check("timeout release", 16'h0, {15'h0, sda_oe});
    i_uvsp_host_model.bus_stop();
    xfer_rd(ADDR_MAIN, 8'h34);
    $display("test timeout done");
    report_and_stop();
  end
endmodule // test_uvsp_i2c_slave
